// ==== inc/pcsr_pkg.sv ====
// Package of constants for the programmer control and status register set
package pcsr_pkg;
	// Port command bytes
	localparam logic [7:0] CMD_RD_STATUS = 8'h02;
	localparam logic [7:0] CMD_WR_CTRL = 8'h04;
	localparam logic [7:0] CMD_RD_CTRL = 8'h05;
	localparam logic [7:0] CMD_WR_FCREG = 8'h08;
	localparam logic [7:0] CMD_WR_BYPASS = 8'hf0;
	localparam logic [7:0] CMD_RD_BYPASS = 8'hf1;
	// Field positions
	localparam int CTRL_MODE_BIT = 7;
	localparam int STAT_MODE_BIT = 7;
	localparam int STAT_PROT1_BIT = 6;
	localparam int STAT_RWP_BIT = 5;
	localparam int STAT_BUSY_BIT = 3;
	localparam int BYP_EN_BIT = 2;
	localparam int OPT1_PROT1_BIT = 1;
	localparam int OPT1_RWP_BIT = 0;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYP_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	// Data byte pattern that requests a device reset through the control register
	localparam logic [6:0] CTRL_RESET_KEY = 7'h00;
	// Length of the device reset request pulse
	localparam int RESET_PULSE_NS = 64;
	localparam int CLK_PERIOD_NS = 8;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pcsr_pkg

// ==== core/pcsr_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pcsr_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_r, s2_r, s3_r, lvl_r;
	logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

	// Only the second stage reads the first; change counts when stages two and three agree
	always_comb begin
		s1_nxt = pin_in;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			lvl_r <= INIT;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;
endmodule : pcsr_sync
`default_nettype wire

// ==== core/pcsr_regs.sv ====
// Control, status and bypass registers of the serial programming port
//
// Contract
// - Control bit 7 written 1 enters flash access mode, 0 returns normal.
// - While mode set, port flash accesses go to the flash controller.
// - Status bit 7 reflects flash access mode.
// - Status bit 6 shows protect option one from option shadow.
// - Status bit 5 shows read/write protect option; 0 means enabled.
// - Status bit 3 is 1 while a port flash operation runs.
// - Bypass register bit 2 routes flash access to I/O pins.
// - Bypass register reserved bits read zero; host writes ones there.
// - Bypass register reached only by its dedicated read/write commands.
// - Control register can also request a device reset.
// - Power-on reset with exit strap high leaves programming mode.
// - Brownout reset leaves programming mode.
// - Status read by command 02h returning one byte; no write.
// - Control written by 04h plus data, read by 05h.
// - Bypass written by F0h plus data, read by F1h.
// - Flash controller register writes are discarded outside flash access mode.
`timescale 1ns/100ps
`default_nettype none
module pcsr_regs (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic por_active,
	input wire logic brownout,
	input wire logic exit_strap_pin,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic data_valid,
	input wire logic [7:0] data_byte,
	input wire logic [7:0] option_byte_one_shadow,
	input wire logic flash_op_start,
	input wire logic flash_op_done,
	input wire logic fc_wr_valid,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic fc_wr_allow,
	output logic flash_ctrl_route,
	output logic bypass_route,
	output logic device_reset_req,
	output logic prog_mode_exit
);
	typedef enum {PCSR_IDLE, PCSR_WAIT_CTRL, PCSR_WAIT_BYP} pcsr_state_t;

	pcsr_state_t st_r, st_nxt;
	logic flash_access_mode_bit_r, flash_access_mode_bit_nxt;
	logic bypass_en_r, bypass_en_nxt;
	logic flash_op_pending_r, flash_op_pending_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic fc_allow_r, fc_allow_nxt;
	logic [7:0] rst_cnt_r, rst_cnt_nxt;
	logic rst_req_r, rst_req_nxt;
	logic exit_r, exit_nxt;
	logic strap_held_r, strap_held_nxt;
	logic por_d_r, por_d_nxt;
	logic strap_lvl;
	logic [7:0] status_byte;

	// Strap comes from a pin, so it passes the synchroniser
	pcsr_sync #(.INIT(1'b0)) u_strap_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.pin_in(exit_strap_pin),
		.level_out(strap_lvl)
	);

	// Status byte assembly; reserved positions read zero
	always_comb begin
		status_byte = pcsr_pkg::STAT_RESET;
		status_byte[pcsr_pkg::STAT_MODE_BIT] = flash_access_mode_bit_r;
		status_byte[pcsr_pkg::STAT_PROT1_BIT] =
			option_byte_one_shadow[pcsr_pkg::OPT1_PROT1_BIT];
		status_byte[pcsr_pkg::STAT_RWP_BIT] =
			option_byte_one_shadow[pcsr_pkg::OPT1_RWP_BIT];
		status_byte[pcsr_pkg::STAT_BUSY_BIT] = flash_op_pending_r;
	end

	// Strap must stay high through the whole power-on reset to count
	always_comb begin
		por_d_nxt = por_active;
		strap_held_nxt = strap_held_r;
		exit_nxt = 1'b0;
		if (por_active && !por_d_r) begin
			strap_held_nxt = strap_lvl;
		end else if (por_active) begin
			strap_held_nxt = strap_held_r & strap_lvl;
		end
		if (!por_active && por_d_r && strap_held_r) begin
			exit_nxt = 1'b1;
		end
		if (brownout) begin
			exit_nxt = 1'b1;
		end
	end

	// Command decode and register updates
	always_comb begin
		st_nxt = st_r;
		flash_access_mode_bit_nxt = flash_access_mode_bit_r;
		bypass_en_nxt = bypass_en_r;
		flash_op_pending_nxt = flash_op_pending_r;
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = 1'b0;
		rst_cnt_nxt = (rst_cnt_r != 8'h00) ? rst_cnt_r - 8'h01 : 8'h00;
		// Start wins over done so a back-to-back operation is never reported idle
		if (flash_op_done) begin
			flash_op_pending_nxt = 1'b0;
		end
		if (flash_op_start && flash_access_mode_bit_r && !bypass_en_r) begin
			flash_op_pending_nxt = 1'b1;
		end
		case (st_r)
			PCSR_IDLE: begin
				if (cmd_valid) begin
					case (cmd_byte)
						pcsr_pkg::CMD_RD_STATUS: begin
							rd_data_nxt = status_byte;
							rd_valid_nxt = 1'b1;
						end
						pcsr_pkg::CMD_WR_CTRL: st_nxt = PCSR_WAIT_CTRL;
						pcsr_pkg::CMD_RD_CTRL: begin
							rd_data_nxt = {flash_access_mode_bit_r, 7'h00};
							rd_valid_nxt = 1'b1;
						end
						pcsr_pkg::CMD_WR_BYPASS: st_nxt = PCSR_WAIT_BYP;
						pcsr_pkg::CMD_RD_BYPASS: begin
							rd_data_nxt = 8'h00;
							rd_data_nxt[pcsr_pkg::BYP_EN_BIT] = bypass_en_r;
							rd_valid_nxt = 1'b1;
						end
						default: st_nxt = PCSR_IDLE;
					endcase
				end
			end
			PCSR_WAIT_CTRL: begin
				if (data_valid) begin
					// Only bit 7 is stored; low bits are only compared with the reset key
					flash_access_mode_bit_nxt = data_byte[pcsr_pkg::CTRL_MODE_BIT];
					if (data_byte[6:0] == pcsr_pkg::CTRL_RESET_KEY) begin
						rst_cnt_nxt = 8'(pcsr_pkg::RESET_PULSE_CYC);
					end
					st_nxt = PCSR_IDLE;
				end
			end
			PCSR_WAIT_BYP: begin
				if (data_valid) begin
					bypass_en_nxt = data_byte[pcsr_pkg::BYP_EN_BIT];
					st_nxt = PCSR_IDLE;
				end
			end
			default: st_nxt = PCSR_IDLE;
		endcase
		if (exit_r) begin
			flash_access_mode_bit_nxt = 1'b0;
			bypass_en_nxt = 1'b0;
			st_nxt = PCSR_IDLE;
		end
		fc_allow_nxt = fc_wr_valid && flash_access_mode_bit_nxt;
		// Request flag is registered so the output comes straight from a flop
		rst_req_nxt = (rst_cnt_nxt != 8'h00);
	end

	// Register stage; all state clears on reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= PCSR_IDLE;
			flash_access_mode_bit_r <= pcsr_pkg::CTRL_RESET[7];
			bypass_en_r <= pcsr_pkg::BYP_RESET[2];
			flash_op_pending_r <= 1'b0;
			rd_data_r <= 8'h00;
			rd_valid_r <= 1'b0;
			fc_allow_r <= 1'b0;
			rst_cnt_r <= 8'h00;
			rst_req_r <= 1'b0;
			exit_r <= 1'b0;
			strap_held_r <= 1'b0;
			por_d_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			flash_access_mode_bit_r <= flash_access_mode_bit_nxt;
			bypass_en_r <= bypass_en_nxt;
			flash_op_pending_r <= flash_op_pending_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			fc_allow_r <= fc_allow_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			rst_req_r <= rst_req_nxt;
			exit_r <= exit_nxt;
			strap_held_r <= strap_held_nxt;
			por_d_r <= por_d_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign fc_wr_allow = fc_allow_r;
	assign flash_ctrl_route = flash_access_mode_bit_r;
	assign bypass_route = bypass_en_r;
	assign device_reset_req = rst_req_r;
	assign prog_mode_exit = exit_r;

	// Write of control sets the mode on the cycle after the data byte
	ctrl_write_a: assert property (@(posedge ref_clk) disable iff (srst)
		(st_r == PCSR_WAIT_CTRL && data_valid && !exit_r)
		|=> flash_access_mode_bit_r == $past(data_byte[7]))
		else $error("Mode bit did not follow control write");
	status_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
		(st_r == PCSR_IDLE && cmd_valid && cmd_byte == 8'h02)
		|=> rd_valid_r && rd_data_r[7] == $past(flash_access_mode_bit_r))
		else $error("Status mode bit wrong");
	status_opt_a: assert property (@(posedge ref_clk) disable iff (srst)
		(st_r == PCSR_IDLE && cmd_valid && cmd_byte == 8'h02)
		|=> rd_data_r[6:5] == $past(option_byte_one_shadow[1:0]))
		else $error("Status option bits wrong");
	busy_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		(flash_op_start && flash_access_mode_bit_r && !bypass_en_r) |=> flash_op_pending_r)
		else $error("Busy not set on operation start");
	busy_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		(flash_op_done && !flash_op_start) |=> !flash_op_pending_r)
		else $error("Busy not cleared on completion");
	byp_read_a: assert property (@(posedge ref_clk) disable iff (srst)
		(st_r == PCSR_IDLE && cmd_valid && cmd_byte == 8'hf1)
		|=> rd_data_r == {5'h00, $past(bypass_en_r), 2'h0})
		else $error("Bypass read wrong");
	byp_only_a: assert property (@(posedge ref_clk) disable iff (srst)
		$changed(bypass_en_r) |-> $past(st_r) == PCSR_WAIT_BYP || $past(exit_r))
		else $error("Bypass changed outside its command");
	fc_discard_a: assert property (@(posedge ref_clk) disable iff (srst)
		fc_allow_r |-> flash_access_mode_bit_r)
		else $error("Controller write passed outside mode");
	exit_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		brownout |=> ##1 !flash_access_mode_bit_r)
		else $error("Brownout did not leave mode");
	reset_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
		(st_r == PCSR_WAIT_CTRL && data_valid && data_byte[6:0] == 7'h00)
		|=> device_reset_req [*8])
		else $error("Reset request pulse too short");
endmodule : pcsr_regs
`default_nettype wire

// ==== sim/pcsr_host.sv ====
// Host model issuing command and data bytes to the register set
`timescale 1ns/100ps
`default_nettype none
module pcsr_host (
	input wire logic ref_clk,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic data_valid,
	output logic [7:0] data_byte,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	// Idle bytes are inverted so a stale value never looks valid
	initial begin
		cmd_valid = 1'b0;
		data_valid = 1'b0;
		cmd_byte = 8'h5a;
		data_byte = 8'ha5;
	end
	// Write command followed by one data byte
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_byte = c;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_byte = ~c;
		data_valid = 1'b1;
		data_byte = d;
		@(negedge ref_clk);
		data_valid = 1'b0;
		data_byte = ~d;
	endtask : wr
	// Read command; answer taken within a short bounded wait
	task automatic rd(input logic [7:0] c, output logic [7:0] q);
		int n;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_byte = c;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_byte = ~c;
		n = 0;
		q = 8'hxx;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(negedge ref_clk);
			n++;
		end
		if (rd_valid === 1'b1) q = rd_data;
	endtask : rd
endmodule : pcsr_host
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the programmer control and status registers
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0, srst = 1'b1, por_active = 1'b0, brownout = 1'b0;
	logic exit_strap_pin = 1'b0, flash_op_start = 1'b0, flash_op_done = 1'b0;
	logic fc_wr_valid = 1'b0, cmd_valid, data_valid, rd_valid, fc_wr_allow;
	logic flash_ctrl_route, bypass_route, device_reset_req, prog_mode_exit;
	logic [7:0] cmd_byte, data_byte, rd_data, q, r, opt = 8'h00;
	logic [7:0] cmds [3] = '{8'h02, 8'h05, 8'hf1};
	int error_cnt = 0, checked = 0, seed = 23, cyc = 0, ne, nr;
	pcsr_regs i_pcsr_regs (.ref_clk(ref_clk), .srst(srst), .por_active(por_active),
		.brownout(brownout), .exit_strap_pin(exit_strap_pin), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .data_valid(data_valid), .data_byte(data_byte),
		.option_byte_one_shadow(opt), .flash_op_start(flash_op_start),
		.flash_op_done(flash_op_done), .fc_wr_valid(fc_wr_valid), .rd_data(rd_data),
		.rd_valid(rd_valid), .fc_wr_allow(fc_wr_allow), .flash_ctrl_route(flash_ctrl_route),
		.bypass_route(bypass_route), .device_reset_req(device_reset_req),
		.prog_mode_exit(prog_mode_exit));
	pcsr_host i_pcsr_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.data_valid(data_valid), .data_byte(data_byte), .rd_data(rd_data),
		.rd_valid(rd_valid));
	// Clock and a ceiling on run length
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Reserved status positions are masked, although the design reads them as zero
	function automatic logic [7:0] stat(input logic m, input logic [7:0] o, input logic b);
		return {m, o[1], o[0], 1'b0, b, 3'h0};
	endfunction : stat
	// Counts exit and reset-request cycles over k cycles
	task automatic watch(input int k);
		ne = 0;
		nr = 0;
		// Sample first so a pulse launched before the call is not missed
		repeat (k) begin
			ne += int'(prog_mode_exit === 1'b1);
			nr += int'(device_reset_req === 1'b1);
			@(negedge ref_clk);
		end
	endtask : watch
	task automatic conclude();
		$display("Errors %0d, checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// Main sequence
	initial begin
		repeat (16) @(negedge ref_clk);
		srst = 1'b0;
		foreach (cmds[i]) begin
			i_pcsr_host.rd(cmds[i], q);
			chk(q, 8'h00);
		end
		fc_wr_valid = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({7'h00, fc_wr_allow}, 8'h00);
		i_pcsr_host.wr(8'h04, 8'hff);
		repeat (2) @(negedge ref_clk);
		chk({7'h00, flash_ctrl_route}, 8'h01);
		chk({7'h00, fc_wr_allow}, 8'h01);
		i_pcsr_host.rd(8'h05, q);
		chk(q, 8'h80);
		fc_wr_valid = 1'b0;
		repeat (6) begin
			opt = 8'($random(seed));
			repeat (3) @(negedge ref_clk);
			i_pcsr_host.rd(8'h02, q);
			chk(q & 8'he8, stat(1'b1, opt, 1'b0));
		end
		flash_op_start = 1'b1;
		@(negedge ref_clk);
		flash_op_start = 1'b0;
		i_pcsr_host.rd(8'h02, q);
		chk(q & 8'he8, stat(1'b1, opt, 1'b1));
		flash_op_done = 1'b1;
		@(negedge ref_clk);
		flash_op_done = 1'b0;
		i_pcsr_host.rd(8'h02, q);
		chk(q & 8'he8, stat(1'b1, opt, 1'b0));
		repeat (5) begin
			r = {5'h1f, 1'($random(seed)), 2'h3};
			i_pcsr_host.wr(8'hf0, r);
			i_pcsr_host.rd(8'hf1, q);
			chk(q, r & 8'h04);
			chk({7'h00, bypass_route}, {7'h00, r[2]});
		end
		i_pcsr_host.wr(8'hf0, 8'hff);
		i_pcsr_host.wr(8'h04, 8'hff);
		i_pcsr_host.rd(8'hf1, q);
		chk(q, 8'h04);
		brownout = 1'b1;
		@(negedge ref_clk);
		brownout = 1'b0;
		watch(4);
		chk(8'(ne > 0), 8'h01);
		chk({6'h00, flash_ctrl_route, bypass_route}, 8'h00);
		i_pcsr_host.wr(8'h04, 8'hff);
		exit_strap_pin = 1'b1;
		repeat (6) @(negedge ref_clk);
		por_active = 1'b1;
		repeat (4) @(negedge ref_clk);
		por_active = 1'b0;
		watch(4);
		chk(8'(ne > 0), 8'h01);
		chk({7'h00, flash_ctrl_route}, 8'h00);
		i_pcsr_host.wr(8'h04, 8'h00);
		watch(16);
		chk(8'(nr), 8'(pcsr_pkg::RESET_PULSE_CYC));
		conclude();
	end
endmodule : testbench
`default_nettype wire
